// file: bench/bst_ctl_model.sv
// Test controller model driving the five-wire test port
// Assumes tdo is settled before each tck rise
`timescale 1ns/1ps
module bst_ctl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_b,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_b = 1'b1;
  end
  // One tck period, tdo taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #100 o = tdo;
    tck = 1'b1;
    #100 tck = 1'b0;
  endtask
  // RTI, shift n bits into IR or DR, back to RTI
  task automatic scan(input logic r, input int n, input logic [19:0] v, output logic [19:0] q);
    logic o;
    q = '0;
    step(1'b1, 1'b0, o);
    if (r)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], o);
      q[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  task automatic tlr();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  task automatic trst();
    trst_b = 1'b0;
    #200 trst_b = 1'b1;
  endtask
endmodule

// file: bench/bst_test_port_chk.sv
// Checker of the test port pins and test data output
// Assumes a bind onto bst_test_port, tck far slower than ref_clk
`timescale 1ns/1ps
module bst_test_port_chk #(
  parameter int PIN_CNT = 19
) (
  input wire logic               ref_clk,
  input wire logic               rst_b,
  input wire logic               tck,
  input wire logic               trst_b,
  input wire logic               tdo,
  input wire logic               tdoOe,
  input wire logic               coreOe,
  input wire logic [PIN_CNT-1:0] pinDi,
  input wire logic [PIN_CNT-1:0] pinOe,
  input wire logic [PIN_CNT-1:0] coreDi
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  mode_cell_a: assert property (pinOe[13] == 1'b0)
    else $error("input-only cell driven");
  rst_quiet_a: assert property (disable iff (1'b0)
    !rst_b |=> pinOe == '0 && tdoOe == 1'b0 && coreDi == '0) else $error("reset outputs");
  core_pass_a: assert property (rst_b [*4] |-> coreDi == $past(pinDi, 2))
    else $error("core input path");
  trst_off_a: assert property (!trst_b [*4] |-> !tdoOe)
    else $error("tdo enabled in test reset");
  group_oe_a: assert property ($countones({pinOe[18:14], pinOe[12:0]}) inside {0, 18})
    else $error("group enable split");
  tdo_fall_a: assert property ($changed(tdo) |-> !$past(tck, 2) || !$past(trst_b, 3))
    else $error("tdo moved off tck fall");
  oe_fall_a: assert property ($changed(tdoOe) |-> !$past(tck, 2) || !$past(trst_b, 3))
    else $error("tdo enable moved off tck fall");
  oe_cause_a: assert property ($changed(pinOe) |-> $past(coreOe) != $past(coreOe, 2)
    || $past(tck, 2) || !$past(rst_b, 2) || !$past(trst_b, 4))
    else $error("pin enable without cause");
  cover property (tdoOe [*3]);
  cover property ($rose(pinOe[0]));
  cover property (!trst_b);
endmodule

bind bst_test_port bst_test_port_chk #(.PIN_CNT(PIN_CNT)) i_chk (.ref_clk(ref_clk),
  .rst_b(rst_b), .tck(tck), .trst_b(trst_b), .tdo(tdo), .tdoOe(tdoOe), .coreOe(coreOe),
  .pinDi(pinDi), .pinOe(pinOe), .coreDi(coreDi));

// file: bench/tb_bst_test_port.sv
// Self-checking bench of the boundary-scan test port
// Assumes bst_ctl_model plays the test controller
`timescale 1ns/1ps
module tb_bst_test_port;
  localparam logic [18:0] M = 19'h7DFFF;
  logic        ref_clk, rst_b, tck, tms, tdi, trst_b, tdo, tdoOe, coreOe;
  logic [18:0] coreDo, pinDi, pinDo, pinOe, coreDi, seen, pd;
  logic [18:0] expQ[$];
  string       nmQ[$];
  event        got;
  int          num_errors = 0;
  int          num_checks = 0;
  bst_test_port i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_b(trst_b), .tdo(tdo), .tdoOe(tdoOe), .coreDo(coreDo), .coreOe(coreOe),
    .pinDi(pinDi), .pinDo(pinDo), .pinOe(pinOe), .coreDi(coreDi));
  bst_ctl_model i_ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Notes and the watcher that settles them
  // ----------------------------------------
  task automatic chk(input string n, input logic [18:0] e, input logic [18:0] s);
    nmQ.push_back(n);
    expQ.push_back(e);
    seen = s;
    ->got;
    #1;
  endtask
  always @(got) begin
    num_checks++;
    if (seen !== expQ[0]) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nmQ[0], expQ[0], seen);
    end
    void'(expQ.pop_front());
    void'(nmQ.pop_front());
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic core(input logic [18:0] d, input logic oe);
    @(posedge ref_clk);
    #2;
    coreDo = d;
    coreOe = oe;
    pinDi = 19'($urandom);
    repeat (4) @(posedge ref_clk);
    #2;
  endtask
  task automatic ir(input logic [4:0] op);
    logic [19:0] q;
    i_ctl.scan(1'b1, 5, 20'(op), q);
    repeat (8) @(posedge ref_clk);
    chk("irCap", 19'h00001, q[18:0]);
  endtask
  task automatic dr(input logic [19:0] v, output logic [19:0] q);
    i_ctl.scan(1'b0, 20, v, q);
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic byp();
    logic [19:0] v, q;
    v = 20'($urandom);
    dr(v, q);
    chk("bypass", {v[17:0], 1'b0}, q[18:0]);
  endtask
  initial begin
    logic [19:0] v, q;
    logic [4:0]  ops [3];
    ops = '{5'h1F, 5'h0A, 5'h13};
    coreDo = '0;
    coreOe = 1'b0;
    pinDi = '0;
    rst_b = 1'b0;
    void'($urandom(16));
    repeat (20) @(posedge ref_clk);
    #2;
    chk("rstOe", 19'h0, pinOe);
    rst_b = 1'b1;
    pd = 19'($urandom);
    core(pd, 1'b1);
    chk("nDo", pd & M, pinDo & M);
    chk("nOe", M, pinOe);
    chk("coreDi", pinDi, coreDi);
    $display("test normal done");
    i_ctl.tlr();
    ir(5'h00);
    v = {1'b1, 19'($urandom)};
    dr(v, q);
    chk("capPin", pinDi, q[18:0]);
    chk("capCtl", 19'(coreOe), 19'(q[19]));
    core(~pd, 1'b0);
    chk("xDo", v[18:0] & M, pinDo & M);
    chk("xOe", M, pinOe);
    $display("test extest done");
    ir(5'h01);
    core(pd, 1'b1);
    chk("sDo", pd & M, pinDo & M);
    v = {1'b1, 19'($urandom)};
    dr(v, q);
    chk("sCap", pinDi, q[18:0]);
    ir(5'h04);
    chk("cDo", v[18:0] & M, pinDo & M);
    chk("cOe", M, pinOe);
    byp();
    ir(5'h05);
    chk("zOe", 19'h0, pinOe);
    byp();
    $display("test clamp highz done");
    foreach (ops[i]) begin
      ir(ops[i]);
      byp();
      chk("bDo", pd & M, pinDo & M);
    end
    i_ctl.trst();
    repeat (4) @(posedge ref_clk);
    chk("tOe", 19'h0, 19'(tdoOe));
    i_ctl.tlr();
    byp();
    $display("test bypass reset done");
    complete_run();
  end
  initial begin
    #400us;
    num_errors++;
    complete_run();
  end
endmodule

// file: rtl/bst_test_port.sv
// Boundary-scan test access port with the lower secondary-bus chain
// Assumes the four test input pins arrive asynchronously and ref_clk is far faster than tck
//
// Overview of operation
// - Provide standard boundary-scan test access port
// - Five pins, controller, IR, bypass, boundary register
// - Opcode 00000 drives pins from boundary
// - Opcode 00001 captures pins, core keeps running
// - Opcode 00100 drives boundary, shifts bypass
// - Opcode 00101 floats all pins except TDO
// - Opcode 11111 shifts through bypass bit
// - Private opcodes reserved for maker test
// - Cells 0 to 18 map lower secondary pins
// - Cell 19 enables group; 13 input-only
`timescale 1ns/1ps

module bst_test_port
  import bst_pkg::*;
#(
  parameter int PIN_CNT = `BST_PIN_CNT
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  input  wire logic               trst_b,
  output logic                    tdo,
  output logic                    tdoOe,
  input  wire logic [PIN_CNT-1:0] coreDo,
  input  wire logic               coreOe,
  input  wire logic [PIN_CNT-1:0] pinDi,
  output logic      [PIN_CNT-1:0] pinDo,
  output logic      [PIN_CNT-1:0] pinOe,
  output logic      [PIN_CNT-1:0] coreDi
);

  localparam int CHAIN = PIN_CNT + 1;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0]         syncA_r;
  logic [3:0]         syncB_r;
  logic               tckDly_r;
  logic [PIN_CNT-1:0] pinA_r;
  logic [PIN_CNT-1:0] pinB_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      // Idle pin levels, so no false tck rise follows reset
      syncA_r  <= 4'h8;
      syncB_r  <= 4'h8;
      tckDly_r <= 1'b0;
      pinA_r   <= '0;
      pinB_r   <= '0;
    end else begin
      syncA_r  <= {trst_b, tdi, tms, tck} ^ 4'h0;
      syncB_r  <= syncA_r;
      tckDly_r <= syncB_r[0];
      pinA_r   <= pinDi;
      pinB_r   <= pinA_r;
    end
  end

  wire tckS    = syncB_r[0];
  wire tmsS    = syncB_r[1];
  wire tdiS    = syncB_r[2];
  wire trstS_b = syncB_r[3];
  wire tckRise = tckS & ~tckDly_r;
  wire tckFall = ~tckS & tckDly_r;

  // ----------------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------------
  bst_tap_state_t state_r;
  bst_tap_state_t state_nxt;

  always_comb begin
    unique case (state_r)
      BST_TLR:   state_nxt = tmsS ? BST_TLR   : BST_RTI;
      BST_RTI:   state_nxt = tmsS ? BST_SELDR : BST_RTI;
      BST_SELDR: state_nxt = tmsS ? BST_SELIR : BST_CAPDR;
      BST_CAPDR: state_nxt = tmsS ? BST_EX1DR : BST_SHDR;
      BST_SHDR:  state_nxt = tmsS ? BST_EX1DR : BST_SHDR;
      BST_EX1DR: state_nxt = tmsS ? BST_UPDR  : BST_PSDR;
      BST_PSDR:  state_nxt = tmsS ? BST_EX2DR : BST_PSDR;
      BST_EX2DR: state_nxt = tmsS ? BST_UPDR  : BST_SHDR;
      BST_UPDR:  state_nxt = tmsS ? BST_SELDR : BST_RTI;
      BST_SELIR: state_nxt = tmsS ? BST_TLR   : BST_CAPIR;
      BST_CAPIR: state_nxt = tmsS ? BST_EX1IR : BST_SHIR;
      BST_SHIR:  state_nxt = tmsS ? BST_EX1IR : BST_SHIR;
      BST_EX1IR: state_nxt = tmsS ? BST_UPIR  : BST_PSIR;
      BST_PSIR:  state_nxt = tmsS ? BST_EX2IR : BST_PSIR;
      BST_EX2IR: state_nxt = tmsS ? BST_UPIR  : BST_SHIR;
      BST_UPIR:  state_nxt = tmsS ? BST_SELDR : BST_RTI;
    endcase
  end

  // Test reset pin forces the controller home at once
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= BST_TLR;
    end else if (!trstS_b) begin
      state_r <= BST_TLR;
    end else if (tckRise) begin
      state_r <= state_nxt;
    end
  end

  wire stepCapIr = tckRise & (state_r == BST_CAPIR);
  wire stepShIr  = tckRise & (state_r == BST_SHIR);
  wire stepUpIr  = tckRise & (state_r == BST_UPIR);
  wire stepCapDr = tckRise & (state_r == BST_CAPDR);
  wire stepShDr  = tckRise & (state_r == BST_SHDR);
  wire stepUpDr  = tckRise & (state_r == BST_UPDR);
  wire inReset   = (state_r == BST_TLR) | ~trstS_b;

  // ----------------------------------------------------------------------
  // Instruction register and decode
  // ----------------------------------------------------------------------
  logic [`BST_IR_W-1:0] irShift_r;
  logic [`BST_IR_W-1:0] irHold_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irShift_r <= `BST_IR_CAPTURE;
      irHold_r  <= `BST_IR_RESET;
    end else if (inReset) begin
      irShift_r <= `BST_IR_CAPTURE;
      irHold_r  <= `BST_IR_RESET;
    end else begin
      if (stepCapIr) begin
        irShift_r <= `BST_IR_CAPTURE;
      end else if (stepShIr) begin
        irShift_r <= {tdiS, irShift_r[`BST_IR_W-1:1]};
      end
      if (stepUpIr) begin
        irHold_r <= irShift_r;
      end
    end
  end

  wire opExtest = (irHold_r == `BST_OP_EXTEST);
  wire opSample = (irHold_r == `BST_OP_SAMPLE);
  wire opClamp  = (irHold_r == `BST_OP_CLAMP);
  wire opHighz  = (irHold_r == `BST_OP_HIGHZ);
  // Boundary register sits in the shift path only for these two
  wire selBsr   = opExtest | opSample;
  // Everything else, private and undecoded codes too, shifts bypass
  wire selByp   = ~selBsr;
  wire drvBsr   = opExtest | opClamp;

  // ----------------------------------------------------------------------
  // Bypass and boundary registers
  // ----------------------------------------------------------------------
  logic             byp_r;
  logic [CHAIN-1:0] bsrShift_r;
  logic [CHAIN-1:0] bsrHold_r;

  // Capture view: pins in cells 0..18, core group enable in cell 19
  wire [CHAIN-1:0] bsrCapture = {coreOe, pinB_r};

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      byp_r      <= 1'b0;
      bsrShift_r <= CHAIN'(`BST_BSR_RESET);
      bsrHold_r  <= CHAIN'(`BST_BSR_RESET);
    end else if (inReset) begin
      byp_r      <= 1'b0;
      bsrHold_r  <= CHAIN'(`BST_BSR_RESET);
    end else begin
      if (stepCapDr && selByp) begin
        byp_r <= 1'b0;
      end else if (stepShDr && selByp) begin
        byp_r <= tdiS;
      end
      if (stepCapDr && selBsr) begin
        bsrShift_r <= bsrCapture;
      end else if (stepShDr && selBsr) begin
        bsrShift_r <= {tdiS, bsrShift_r[CHAIN-1:1]};
      end
      // Update only under the boundary instructions, so CLAMP holds
      if (stepUpDr && selBsr) begin
        bsrHold_r <= bsrShift_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Test data output, changes on tck falling edge
  // ----------------------------------------------------------------------
  logic tdo_r;
  logic tdoOe_r;

  wire shifting = (state_r == BST_SHDR) | (state_r == BST_SHIR);
  wire tdoSel   = (state_r == BST_SHIR) ? irShift_r[0] :
                  selBsr                ? bsrShift_r[0] : byp_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tdo_r   <= 1'b0;
      tdoOe_r <= 1'b0;
    end else if (!trstS_b) begin
      // Controller reset by tms waits for the next tck fall
      tdo_r   <= 1'b0;
      tdoOe_r <= 1'b0;
    end else if (tckFall) begin
      tdo_r   <= tdoSel;
      tdoOe_r <= shifting;
    end
  end

  assign tdo   = tdo_r;
  assign tdoOe = tdoOe_r;

  // ----------------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------------
  logic [PIN_CNT-1:0] pinDo_r;
  logic [PIN_CNT-1:0] pinOe_r;

  // Mode-select cell is input only: never driven, no group disable
  wire [PIN_CNT-1:0] drvMask  = ~(PIN_CNT'(1) << `BST_MODE_POS);
  wire               grpOe    = bsrHold_r[`BST_CTRL_POS];
  wire [PIN_CNT-1:0] testOe   = {PIN_CNT{grpOe}} & drvMask;
  wire [PIN_CNT-1:0] funcOe   = {PIN_CNT{coreOe}} & drvMask;
  wire [PIN_CNT-1:0] oeNxt    = opHighz ? '0 : (drvBsr ? testOe : funcOe);
  wire [PIN_CNT-1:0] doNxt    = drvBsr ? bsrHold_r[PIN_CNT-1:0] : coreDo;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pinDo_r <= '0;
      pinOe_r <= '0;
    end else begin
      pinDo_r <= doNxt;
      pinOe_r <= oeNxt;
    end
  end

  assign pinDo  = pinDo_r;
  assign pinOe  = pinOe_r;
  // Core sees the live pins in every mode, so SAMPLE does not disturb it
  assign coreDi = pinB_r;

endmodule

// file: shared/bst_pkg.sv
// Types of the boundary-scan test port
// Assumes bst_regs.svh sits on the include path
package bst_pkg;
  `include "bst_regs.svh"

  typedef enum logic [3:0] {
    BST_TLR   = 4'h0,
    BST_RTI   = 4'h1,
    BST_SELDR = 4'h2,
    BST_CAPDR = 4'h3,
    BST_SHDR  = 4'h4,
    BST_EX1DR = 4'h5,
    BST_PSDR  = 4'h6,
    BST_EX2DR = 4'h7,
    BST_UPDR  = 4'h8,
    BST_SELIR = 4'h9,
    BST_CAPIR = 4'hA,
    BST_SHIR  = 4'hB,
    BST_EX1IR = 4'hC,
    BST_PSIR  = 4'hD,
    BST_EX2IR = 4'hE,
    BST_UPIR  = 4'hF
  } bst_tap_state_t;
endpackage

// file: shared/bst_regs.svh
// Constants of the boundary-scan test port: opcodes, chain layout, resets
// Assumes inclusion by bst_pkg.sv and by the design files that need them
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// ----------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------
`define BST_IR_W        5
`define BST_OP_EXTEST   5'h00
`define BST_OP_SAMPLE   5'h01
`define BST_OP_CLAMP    5'h04
`define BST_OP_HIGHZ    5'h05
`define BST_OP_BYPASS   5'h1F
`define BST_IR_CAPTURE  5'h01
`define BST_IR_RESET    5'h1F

// ----------------------------------------------------------------------
// Boundary chain
// ----------------------------------------------------------------------
`define BST_PIN_CNT     19
`define BST_CHAIN_LEN   20
`define BST_CTRL_POS    19
`define BST_MODE_POS    13
`define BST_BSR_RESET   20'h00000

`endif
